//--- common/csst_consts.svh
// constants of the conversion and supply status bank
// included by the design file; definitions only
`ifndef CSST_CONSTS_SVH
`define CSST_CONSTS_SVH

// register indices; byte address is four times the index
`define CSST_IDX_PROGRESS   8'h02
`define CSST_IDX_SUPPLY     8'h03
`define CSST_IDX_IRQ_STAT   8'h10
`define CSST_IDX_IRQ_MASK   8'h11

// progress register field positions
`define CSST_SEQ_CNT_LO     14
`define CSST_SHA_CNT_LO     10
`define CSST_SHB_CNT_LO     8
`define CSST_SEQ_RUN_BIT    1

// supply register field layout
`define CSST_FLAG_LO        4
`define CSST_FLAG_W         12

// reset values
`define CSST_CNT_RST        2'h0
`define CSST_FLAG_RST       12'hFFF
`define CSST_IRQ_RST        4'h0
`define CSST_RD_ZERO        32'h0000_0000

`endif

//--- common/csst_pkg.sv
// types shared by the conversion and supply status bank
// constants live in csst_consts.svh
`default_nettype none

package csst_pkg;

    // one bit per supply monitor, msb first as in the register
    typedef struct packed {
        logic analog_rail_over;
        logic analog_rail_under;
        logic io_rail_over;
        logic io_rail_under;
        logic digital_rail_over;
        logic digital_rail_under;
        logic analog_rail_osc;
        logic io_rail_osc;
        logic digital_rail_osc;
        logic analog_reg_hot;
        logic io_reg_hot;
        logic analog_reg_climit;
    } csst_rail_s;

    // one bit per converter
    typedef struct packed {
        logic mux_converter;
        logic shunt_converter_a;
        logic shunt_converter_b;
    } csst_conv_s;

    // interrupt status and mask layout
    typedef struct packed {
        logic supply_fault;
        logic sequence_done;
        logic shunt_a_done;
        logic shunt_b_done;
    } csst_irq_s;

    typedef enum logic [1:0] {
        CSST_BUS_IDLE = 2'b01,
        CSST_BUS_ACK  = 2'b10
    } csst_bus_e;

endpackage

`default_nettype wire

//--- logic/csst_status.sv
// conversion progress counters and sticky supply fault flags
// behind a classic wishbone slave with a masked level interrupt.
// assumes converter strobes and enables come from logic on clk;
// the raw supply monitor levels are asynchronous and are synchronised.
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "csst_consts.svh"

// Operation
// - two-bit wrapping sequence counter in bits 15:14, steps per finished sequence
// - sequence counter clears on converter disable, standby or reset
// - shunt a conversion counter in bits 11:10, wraps, same clear causes
// - shunt b conversion counter in bits 9:8, wraps, same clear causes
// - bit 1 is high exactly while a sequence runs
// - analog overvoltage drops flag bit 15 to zero
// - analog undervoltage drops flag bit 14 to zero
// - io overvoltage drops flag bit 13 to zero
// - io undervoltage drops flag bit 12 to zero
// - digital overvoltage drops flag bit 11 to zero
// - digital undervoltage drops flag bit 10 to zero
// - rail oscillation drops bits 9, 8, 7 for analog, io, digital
// - regulator overtemperature drops bit 6 analog, bit 5 io
// - analog regulator current limit drops bit 4
// - flags reset to one, stay zero until host writes one
module csst_status
    import csst_pkg::*;
#(
    parameter int ADR_W = 10
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // wishbone slave
    input  wire logic             wb_cyc,
    input  wire logic             wb_stb,
    input  wire logic             wb_we,
    input  wire logic [ADR_W-1:0] wb_adr,
    input  wire logic [3:0]       wb_sel,
    input  wire logic [31:0]      wb_dat_w,
    output var  logic [31:0]      wb_dat_r,
    output logic                  wb_ack,
    // converter side, synchronous to clk
    input  wire csst_conv_s       conv_enable,
    input  wire csst_conv_s       conv_done,
    input  wire logic             seq_start,
    input  wire logic             standby,
    // supply monitors, asynchronous, high while a fault is present
    input  wire csst_rail_s       rail_fault_raw,
    // status out
    output var  logic             sequence_running,
    output logic                  irq
);

    // ************************************************************
    // helpers
    // ************************************************************

    // true when the word address selects the given register index
    function automatic logic reg_hit(
        input logic [ADR_W-1:0] adr,
        input logic [7:0]       idx
    );
        logic [ADR_W-3:0] word;
        word = adr[ADR_W-1:2];
        reg_hit = (word == (ADR_W-2)'(idx));
    endfunction

    // low sixteen write bits, each byte kept only if its lane is selected
    function automatic logic [15:0] lane_bits(
        input logic [3:0]  sel,
        input logic [31:0] dat
    );
        logic [15:0] v;
        v = 16'h0000;
        if (sel[1]) begin
            v[15:8] = dat[15:8];
        end
        if (sel[0]) begin
            v[7:0] = dat[7:0];
        end
        lane_bits = v;
    endfunction

    // wrapping two-bit counter step; a clear beats a step
    function automatic logic [1:0] cnt_step(
        input logic [1:0] cnt,
        input logic       clr,
        input logic       inc
    );
        logic [1:0] v;
        v = cnt;
        if (clr) begin
            v = `CSST_CNT_RST;
        end else if (inc) begin
            v = cnt + 2'h1;
        end
        cnt_step = v;
    endfunction

    // ************************************************************
    // declarations
    // ************************************************************

    csst_bus_e        bus_state;
    csst_bus_e        next_bus_state;
    csst_rail_s       fault_meta;
    csst_rail_s       fault_sync;
    csst_rail_s       fault_flag_n;
    csst_irq_s        irq_status;
    csst_irq_s        irq_mask;
    csst_irq_s        irq_event;
    logic [1:0]       seq_count;
    logic [1:0]       sha_count;
    logic [1:0]       shb_count;
    logic             seq_clear;
    logic             sha_clear;
    logic             shb_clear;
    logic             req;
    logic             wr_commit;
    logic [15:0]      wr_bits;
    logic [15:0]      progress_word;
    logic [31:0]      next_rd_data;

    // ************************************************************
    // bus slave
    // ************************************************************

    assign req = wb_cyc & wb_stb;

    // the master holds the request until it sees ack, so the write
    // lands on that same edge and is never applied twice
    assign wr_commit = req & wb_we & (bus_state == CSST_BUS_ACK);
    assign wr_bits   = lane_bits(wb_sel, wb_dat_w);

    always_comb begin
        next_bus_state = bus_state;
        unique case (bus_state)
            CSST_BUS_IDLE: begin
                if (req) begin
                    next_bus_state = CSST_BUS_ACK;
                end
            end
            CSST_BUS_ACK: begin
                next_bus_state = CSST_BUS_IDLE;
            end
            default: begin
                next_bus_state = CSST_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            bus_state <= CSST_BUS_IDLE;
        end else begin
            bus_state <= next_bus_state;
        end
    end

    assign wb_ack = (bus_state == CSST_BUS_ACK);

    // ************************************************************
    // read path
    // ************************************************************

    always_comb begin
        progress_word = 16'h0000;
        progress_word[`CSST_SEQ_CNT_LO +: 2] = seq_count;
        progress_word[`CSST_SHA_CNT_LO +: 2] = sha_count;
        progress_word[`CSST_SHB_CNT_LO +: 2] = shb_count;
        progress_word[`CSST_SEQ_RUN_BIT]     = sequence_running;
    end

    // unmapped addresses still get an ack, with zero data
    always_comb begin
        next_rd_data = `CSST_RD_ZERO;
        if (reg_hit(wb_adr, `CSST_IDX_PROGRESS)) begin
            next_rd_data = {16'h0000, progress_word};
        end else if (reg_hit(wb_adr, `CSST_IDX_SUPPLY)) begin
            next_rd_data[`CSST_FLAG_LO +: `CSST_FLAG_W] = fault_flag_n;
        end else if (reg_hit(wb_adr, `CSST_IDX_IRQ_STAT)) begin
            next_rd_data[3:0] = irq_status;
        end else if (reg_hit(wb_adr, `CSST_IDX_IRQ_MASK)) begin
            next_rd_data[3:0] = irq_mask;
        end
    end

    // data is captured as the request is accepted and held while ack is up
    always_ff @(posedge clk) begin
        if (srst) begin
            wb_dat_r <= `CSST_RD_ZERO;
        end else if (req && bus_state == CSST_BUS_IDLE && !wb_we) begin
            wb_dat_r <= next_rd_data;
        end
    end

    // ************************************************************
    // sequence state
    // ************************************************************

    assign seq_clear = !conv_enable.mux_converter || standby;

    // a done and a new start in one cycle leave the sequencer running
    always_ff @(posedge clk) begin
        if (srst) begin
            sequence_running <= 1'b0;
        end else if (seq_clear) begin
            sequence_running <= 1'b0;
        end else if (seq_start) begin
            sequence_running <= 1'b1;
        end else if (conv_done.mux_converter) begin
            sequence_running <= 1'b0;
        end
    end

    // ************************************************************
    // conversion counters
    // ************************************************************

    assign sha_clear = !conv_enable.shunt_converter_a || standby;
    assign shb_clear = !conv_enable.shunt_converter_b || standby;

    // no write path reaches the counters
    always_ff @(posedge clk) begin
        if (srst) begin
            seq_count <= `CSST_CNT_RST;
        end else begin
            seq_count <= cnt_step(seq_count, seq_clear,
                                  conv_done.mux_converter);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sha_count <= `CSST_CNT_RST;
        end else begin
            sha_count <= cnt_step(sha_count, sha_clear,
                                  conv_done.shunt_converter_a);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            shb_count <= `CSST_CNT_RST;
        end else begin
            shb_count <= cnt_step(shb_count, shb_clear,
                                  conv_done.shunt_converter_b);
        end
    end

    // ************************************************************
    // supply monitor synchroniser
    // ************************************************************

    // monitor levels come from analog comparators outside this clock
    always_ff @(posedge clk) begin
        if (srst) begin
            fault_meta <= '0;
            fault_sync <= '0;
        end else begin
            fault_meta <= rail_fault_raw;
            fault_sync <= fault_meta;
        end
    end

    // ************************************************************
    // supply fault flags
    // ************************************************************

    // write-one restores a flag, but a fault still present wins, so a
    // flag cannot read as clean while its monitor is tripped
    always_ff @(posedge clk) begin
        if (srst) begin
            fault_flag_n <= `CSST_FLAG_RST;
        end else begin
            if (wr_commit && reg_hit(wb_adr, `CSST_IDX_SUPPLY)) begin
                fault_flag_n <= (fault_flag_n
                    | wr_bits[`CSST_FLAG_LO +: `CSST_FLAG_W])
                    & ~fault_sync;
            end else begin
                fault_flag_n <= fault_flag_n & ~fault_sync;
            end
        end
    end
    // field-by-field mapping of monitor to flag, through the struct:
    // analog over/io over/
    // digital over/oscillation
    // overtemperature current limit

    // ************************************************************
    // interrupt status and mask
    // ************************************************************

    // a new fault is one that hits a flag still reading clean
    assign irq_event.supply_fault  = |(fault_flag_n & fault_sync);
    assign irq_event.sequence_done = conv_done.mux_converter & ~seq_clear;
    assign irq_event.shunt_a_done  = conv_done.shunt_converter_a & ~sha_clear;
    assign irq_event.shunt_b_done  = conv_done.shunt_converter_b & ~shb_clear;

    // an event in the same cycle as a write-one-to-clear is kept
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_status <= `CSST_IRQ_RST;
        end else if (wr_commit && reg_hit(wb_adr, `CSST_IDX_IRQ_STAT)) begin
            irq_status <= (irq_status & ~wr_bits[3:0]) | irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_mask <= `CSST_IRQ_RST;
        end else if (wr_commit && reg_hit(wb_adr, `CSST_IDX_IRQ_MASK)) begin
            irq_mask <= wr_bits[3:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

endmodule

`default_nettype wire

//--- tb/csst_status_sva.sv
// concurrent checks for the conversion and supply status bank
// sees only csst_status ports; bound to every instance below
`timescale 1ns/1ps
`default_nettype none
module csst_status_sva
    import csst_pkg::*;
#(
    parameter int ADR_W = 10
) (
    input wire logic             clk,
    input wire logic             srst,
    input wire logic             wb_cyc,
    input wire logic             wb_stb,
    input wire logic             wb_we,
    input wire logic [ADR_W-1:0] wb_adr,
    input wire logic [3:0]       wb_sel,
    input wire logic [31:0]      wb_dat_w,
    input wire logic [31:0]      wb_dat_r,
    input wire logic             wb_ack,
    input wire csst_conv_s       conv_enable,
    input wire csst_conv_s       conv_done,
    input wire logic             seq_start,
    input wire logic             standby,
    input wire csst_rail_s       rail_fault_raw,
    input wire logic             sequence_running,
    input wire logic             irq
);
    logic rd_prog;
    logic rd_sup;
    // lower two address bits are ignored by the slave
    assign rd_prog = wb_cyc && wb_stb && !wb_we && wb_adr[ADR_W-1:2] == (ADR_W-2)'(2);
    assign rd_sup  = wb_cyc && wb_stb && !wb_we && wb_adr[ADR_W-1:2] == (ADR_W-2)'(3);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // ****************
    // assertions
    // ****************
    chk_ack_single: assert property (wb_ack |=> !wb_ack)
        else $error("ack longer than one cycle");
    chk_ack_timely: assert property ($rose(wb_cyc && wb_stb) |=> wb_ack)
        else $error("no ack one cycle after request");
    chk_ack_has_req: assert property (wb_ack |-> $past(wb_cyc && wb_stb))
        else $error("ack without request");
    chk_prog_zeros: assert property (
        wb_ack && $past(rd_prog) |-> wb_dat_r[31:16] == 0 && wb_dat_r[13:12] == 0
        && wb_dat_r[7:2] == 0 && !wb_dat_r[0]) else $error("unused progress bits set");
    chk_run_readback: assert property (
        wb_ack && $past(rd_prog) |-> wb_dat_r[1] == $past(sequence_running))
        else $error("running bit disagrees with output");
    chk_sup_zeros: assert property (wb_ack && $past(rd_sup) |-> wb_dat_r[31:16] == 0
        && wb_dat_r[3:0] == 0) else $error("unused supply bits set");
    chk_run_start: assert property (
        seq_start && conv_enable.mux_converter && !standby |=> sequence_running)
        else $error("sequence start not shown");
    chk_run_stop: assert property (
        conv_done.mux_converter && !seq_start |=> !sequence_running)
        else $error("running after sequence end");
    chk_run_off: assert property (
        !conv_enable.mux_converter || standby |=> !sequence_running)
        else $error("running while disabled");
    chk_irq_cause: assert property ($rose(irq) |-> $past(wb_ack && wb_we)
        || $past(|conv_done) || $past(|rail_fault_raw, 3))
        else $error("interrupt without cause");
    chk_mask_off: assert property (wb_ack && wb_cyc && wb_stb && wb_we && wb_sel[0]
        && wb_dat_w[3:0] == 4'h0 && wb_adr[ADR_W-1:2] == (ADR_W-2)'(8'h11) |=> !irq)
        else $error("interrupt with mask cleared");
    cov_run: cover property ($rose(sequence_running));
    cov_irq: cover property ($rose(irq));
    cov_read: cover property (wb_ack && $past(rd_sup));
endmodule

bind csst_status csst_status_sva #(.ADR_W(ADR_W)) u_sva (
    .clk(clk), .srst(srst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .conv_enable(conv_enable), .conv_done(conv_done),
    .seq_start(seq_start), .standby(standby), .rail_fault_raw(rail_fault_raw),
    .sequence_running(sequence_running), .irq(irq));
`default_nettype wire

//--- tb/csst_status_bench.sv
// self-checking bench for csst_status
// drives every port itself; one clock, no far-side model
`timescale 1ns/1ps
`default_nettype none
module csst_status_bench import csst_pkg::*;;
    logic        clk, srst, wb_cyc, wb_stb, wb_we, wb_ack;
    logic        seq_start, standby, sequence_running, irq;
    logic [9:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, tmp;
    csst_conv_s  conv_enable, conv_done;
    csst_rail_s  rail_fault_raw;
    int          errors, check_count;

    csst_status dut (.clk(clk), .srst(srst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
        .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .conv_enable(conv_enable),
        .conv_done(conv_done), .seq_start(seq_start), .standby(standby),
        .rail_fault_raw(rail_fault_raw), .sequence_running(sequence_running),
        .irq(irq));

    // ****************
    // tasks
    // ****************
    task automatic test_done;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // classic single cycle; waits for ack, then releases
    // no local limit: only the watchdog ends a hung wait
    task automatic xfer(input logic we, input logic [9:0] adr, input logic [31:0] dw);
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_sel <= 4'hF;
        wb_adr <= adr;
        wb_dat_w <= dw;
        do begin
            @(posedge clk);
        end while (wb_ack !== 1'b1);
        tmp = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] adr, input logic [31:0] exp);
        xfer(1'b0, adr, 32'h0);
        chk(tmp, exp);
    endtask

    task automatic wr(input logic [9:0] adr, input logic [31:0] d);
        xfer(1'b1, adr, d);
    endtask

    task automatic pulse(input logic [2:0] d, input logic s);
        @(posedge clk);
        conv_done <= d;
        seq_start <= s;
        @(posedge clk);
        conv_done <= 3'h0;
        seq_start <= 1'b0;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // bench needs about 360 cycles
    initial begin
        #200000;
        errors++;
        $display("BAD %0t watchdog", $time);
        test_done;
    end

    // ****************
    // scenarios
    // ****************
    initial begin
        {srst, wb_cyc, wb_stb, wb_we, seq_start, standby} = 6'h20;
        wb_adr = 10'h0;
        wb_sel = 4'hF;
        wb_dat_w = 32'h0;
        conv_enable = 3'h7;
        conv_done = 3'h0;
        rail_fault_raw = 12'h0;
        errors = 0;
        check_count = 0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        rd(10'h008, 32'h0);
        rd(10'h00C, 32'hFFF0);
        rd(10'h040, 32'h0);
        rd(10'h044, 32'h0);
        rd(10'h3FC, 32'h0);
        // five shunt a conversions exercise the wrap
        repeat (5) pulse(3'h2, 1'b0);
        repeat (2) pulse(3'h1, 1'b0);
        pulse(3'h0, 1'b1);
        rd(10'h008, 32'h0602);
        repeat (3) pulse(3'h4, 1'b0);
        rd(10'h008, 32'hC600);
        wr(10'h008, 32'hFFFF);
        rd(10'h008, 32'hC600);
        pulse(3'h0, 1'b1);
        // disabling the mux converter while a sequence runs, then shunt a, clears their counters; standby clears shunt b
        @(posedge clk) conv_enable <= 3'h3;
        rd(10'h008, 32'h0600);
        @(posedge clk) conv_enable <= 3'h1;
        rd(10'h008, 32'h0200);
        @(posedge clk) conv_enable <= 3'h7;
        standby <= 1'b1;
        rd(10'h008, 32'h0);
        standby <= 1'b0;
        for (int k = 0; k < 12; k++) begin
            @(posedge clk) rail_fault_raw <= csst_rail_s'(12'h1 << k);
            @(posedge clk) rail_fault_raw <= 12'h0;
            repeat (4) @(posedge clk);
            rd(10'h00C, 32'hFFF0 & ~(32'h10 << k));
            wr(10'h00C, 32'h0);
            rd(10'h00C, 32'hFFF0 & ~(32'h10 << k));
            wr(10'h00C, 32'h10 << k);
            rd(10'h00C, 32'hFFF0);
        end
        // a fault still present outweighs the restoring write
        @(posedge clk) rail_fault_raw <= 12'h1;
        repeat (4) @(posedge clk);
        wr(10'h00C, 32'h10);
        rd(10'h00C, 32'hFFE0);
        rail_fault_raw <= 12'h0;
        repeat (4) @(posedge clk);
        wr(10'h00C, 32'h10);
        rd(10'h00C, 32'hFFF0);
        rd(10'h040, 32'hF);
        chk({31'h0, irq}, 32'h0);
        wr(10'h044, 32'h8);
        @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        // masking silences the output while the status stays set
        wr(10'h044, 32'h0);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        wr(10'h044, 32'h8);
        wr(10'h040, 32'hF);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        rd(10'h040, 32'h0);
        test_done;
    end
endmodule
`default_nettype wire
